// >>> hw/jep_defs.vh
// Constants of the test and emulation port
// Summary of operation
// - Test clock is sampled by the system clock and its edges found after synchronising.
// - The TAP controller walks the standard sixteen-state test access port sequence.
// - Mode select steers the states; data enters on data-in, leaves on data-out.
// - Test reset forces the TAP controller into its reset state from any state.
// - An extra emulation pin tells the emulator the processor finished an operation.
// - Every input pin has a scan cell that samples it or substitutes a value.
// - Every output pin has a scan cell that samples it or drives a value.
// - Two-way pins carry both the input and the output scan functions.
// - All pin scan cells form one serial path stepped by the test clock.
// - Emulation can halt the core, let the emulator work, then resume it.
// - Breakpoint start and end addresses sit in the peripheral I/O space.
// - Emulation state and both cycle counters are read-only to the core.
// - Telemetry buffers are mapped to the core and reachable by the emulator live.
// - A 32-bit telemetry status register enables telemetry and reports buffer full/empty.
// - Raise low-priority interrupts on input buffer full and output buffer empty.
// - Telemetry interrupts go through the core's normal priority, mask and vector path.
// - Core accesses inside the breakpoint address range raise a breakpoint interrupt.
// - A breakpoint during return from a prior breakpoint handler may go unrecorded.
// - An instruction breakpoint just after a short loop can fire spuriously.
// - An 8-bit revision register at a fixed I/O address, readable by instruction.
// - The 5-bit instruction register loads all ones (bypass) on TAP reset.
`ifndef JEP_DEFS_VH
`define JEP_DEFS_VH
`define JEP_IR_W          5
`define JEP_IR_BYPASS     5'h1f
`define JEP_IR_EXTEST     5'h00
`define JEP_IR_SAMPLE     5'h10
`define JEP_IR_INTEST     5'h18
`define JEP_IR_BRKSTAT    5'h1c
`define JEP_IR_TLM_IN     5'h09
`define JEP_IR_TLM_OUT    5'h0b
`define JEP_IR_REVID      5'h1d
`define JEP_IR_XFER       5'h1e
`define JEP_IR_EMUCTL     5'h1a
`define JEP_IR_CAPTURE    5'h01
`define JEP_REVID_ADDR    20'h30026
`define JEP_BRK_START_ADDR 20'h30020
`define JEP_BRK_END_ADDR  20'h30021
`define JEP_TLM_STAT_ADDR 20'h30022
`define JEP_TLM_IN_ADDR   20'h30023
`define JEP_TLM_OUT_ADDR  20'h30024
`define JEP_EMU_STATE_ADDR 20'h30025
`define JEP_CYC_LO_ADDR   20'h30027
`define JEP_CYC_HI_ADDR   20'h30028
`define JEP_STAT_EN_BIT   0
`define JEP_STAT_INF_BIT  1
`define JEP_STAT_OUTE_BIT 2
`define JEP_CTL_HALT_BIT  0
`define JEP_CTL_BRKEN_BIT 1
`define JEP_CTL_DONE_BIT  2
`define JEP_CTL_W         3
`endif

// >>> hw/jep_port.v
// Test access port, boundary scan and emulation support
`timescale 1ns/1ns
`default_nettype none
`include "jep_defs.vh"
module jep_port #(
   parameter NPIN = 4,
   parameter DW = 32,
   parameter AW = 20,
   parameter [7:0] REVISION = 8'h5a   // Arbitrary value
) (
   // Clock and reset
   input  wire            clock_in,
   input  wire            rst_n_in,
   input  wire            clk_en_in,
   // Test access pins
   input  wire            tck_in,
   input  wire            tms_in,
   input  wire            tdi_in,
   input  wire            trst_n_in,
   output wire            tdo_out,
   output wire            tdo_oe_out,
   output wire            emulation_done_pin_n_out,
   // Device pins through the scan cells
   input  wire [NPIN-1:0] pin_in,
   output wire [NPIN-1:0] pin_out,
   output wire [NPIN-1:0] pin_oe_out,
   // Core side of the pins
   output wire [NPIN-1:0] core_pin_in_out,
   input  wire [NPIN-1:0] core_pin_out_in,
   input  wire [NPIN-1:0] core_pin_oe_in,
   // Core register access
   input  wire            io_rd_in,
   input  wire            io_wr_in,
   input  wire [AW-1:0]   io_addr_in,
   input  wire [DW-1:0]   io_wdata_in,
   output reg  [DW-1:0]   io_rdata_out,
   // Core activity, halt and interrupts
   input  wire            core_access_in,
   input  wire [AW-1:0]   core_addr_in,
   input  wire            core_op_done_in,
   input  wire [DW-1:0]   core_transfer_reg_in,
   output wire [DW-1:0]   core_transfer_reg_out,
   output wire            core_halt_out,
   output wire            tlm_in_full_irq_out,
   output wire            tlm_out_empty_irq_out,
   output wire            brk_irq_out
);
   // ------------------------------------------------------------
   // Pin synchronisers and test clock edges
   // ------------------------------------------------------------
   reg [3:0]      s1_q;
   reg [3:0]      s2_q;
   reg            tck_d1_q;
   reg [NPIN-1:0] p1_q;
   reg [NPIN-1:0] p2_q;
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_q     <= 4'h0;
         s2_q     <= 4'h0;
         tck_d1_q <= 1'b0;
         p1_q     <= {NPIN{1'b0}};
         p2_q     <= {NPIN{1'b0}};
      end else if (clk_en_in) begin
         s1_q     <= {trst_n_in, tdi_in, tms_in, tck_in};
         s2_q     <= s1_q;
         tck_d1_q <= s2_q[0];
         p1_q     <= pin_in;
         p2_q     <= p1_q;
      end
   end
   wire tck_s    = s2_q[0];
   wire tms_s    = s2_q[1];
   wire tdi_s    = s2_q[2];
   wire trst_n_s = s2_q[3];
   wire tck_rise = tck_s & ~tck_d1_q;
   wire tck_fall = ~tck_s & tck_d1_q;

   // ------------------------------------------------------------
   // TAP controller
   // ------------------------------------------------------------
   localparam [15:0] ST_TLR = 16'h0001,
                     ST_RTI = 16'h0002,
                     ST_SDS = 16'h0004,
                     ST_CDR = 16'h0008,
                     ST_SDR = 16'h0010,
                     ST_E1D = 16'h0020,
                     ST_PDR = 16'h0040,
                     ST_E2D = 16'h0080,
                     ST_UDR = 16'h0100,
                     ST_SIS = 16'h0200,
                     ST_CIR = 16'h0400,
                     ST_SIR = 16'h0800,
                     ST_E1I = 16'h1000,
                     ST_PIR = 16'h2000,
                     ST_E2I = 16'h4000,
                     ST_UIR = 16'h8000;
   reg [15:0] st_q;
   reg [15:0] st_d;
   always @* begin
      st_d = ST_TLR;
      case (st_q)
         ST_TLR: st_d = tms_s ? ST_TLR : ST_RTI;
         ST_RTI: st_d = tms_s ? ST_SDS : ST_RTI;
         ST_SDS: st_d = tms_s ? ST_SIS : ST_CDR;
         ST_CDR: st_d = tms_s ? ST_E1D : ST_SDR;
         ST_SDR: st_d = tms_s ? ST_E1D : ST_SDR;
         ST_E1D: st_d = tms_s ? ST_UDR : ST_PDR;
         ST_PDR: st_d = tms_s ? ST_E2D : ST_PDR;
         ST_E2D: st_d = tms_s ? ST_UDR : ST_SDR;
         ST_UDR: st_d = tms_s ? ST_SDS : ST_RTI;
         ST_SIS: st_d = tms_s ? ST_TLR : ST_CIR;
         ST_CIR: st_d = tms_s ? ST_E1I : ST_SIR;
         ST_SIR: st_d = tms_s ? ST_E1I : ST_SIR;
         ST_E1I: st_d = tms_s ? ST_UIR : ST_PIR;
         ST_PIR: st_d = tms_s ? ST_E2I : ST_PIR;
         ST_E2I: st_d = tms_s ? ST_UIR : ST_SIR;
         ST_UIR: st_d = tms_s ? ST_SDS : ST_RTI;
         default: st_d = ST_TLR;
      endcase
   end

   // ------------------------------------------------------------
   // Instruction and data registers
   // ------------------------------------------------------------
   reg [`JEP_IR_W-1:0] ir_sh_q;
   reg [`JEP_IR_W-1:0] ir_q;
   reg [2*NPIN-1:0]    bsr_sh_q;
   reg [2*NPIN-1:0]    bsr_q;
   reg [DW-1:0]        dr_sh_q;
   reg [DW-1:0]        xfer_q;
   reg [`JEP_CTL_W-1:0] ctl_q;
   reg                 byp_q;
   reg                 tdo_q;
   reg                 tdo_oe_q;
   reg [DW-1:0]        tlm_in_q;
   reg [DW-1:0]        tlm_out_q;
   reg                 tlm_in_full_q;
   reg                 tlm_out_full_q;
   reg                 brk_hit_q;

   wire in_test  = (ir_q == `JEP_IR_INTEST);
   wire out_test = (ir_q == `JEP_IR_EXTEST) | in_test;
   wire sel_bsr  = (ir_q == `JEP_IR_EXTEST) | (ir_q == `JEP_IR_SAMPLE) | in_test;
   wire sel_word = (ir_q == `JEP_IR_TLM_IN) | (ir_q == `JEP_IR_TLM_OUT) |
                   (ir_q == `JEP_IR_REVID) | (ir_q == `JEP_IR_XFER) |
                   (ir_q == `JEP_IR_BRKSTAT) | (ir_q == `JEP_IR_EMUCTL);
   wire [2*NPIN-1:0] bsr_cap = {core_pin_out_in, p2_q};

   reg [DW-1:0] cap_word;
   always @* begin
      cap_word = {DW{1'b0}};
      if (ir_q == `JEP_IR_REVID)
         cap_word = {{(DW-8){1'b0}}, REVISION};
      else if (ir_q == `JEP_IR_TLM_OUT)
         cap_word = tlm_out_q;
      else if (ir_q == `JEP_IR_XFER)
         cap_word = xfer_q;
      else if (ir_q == `JEP_IR_BRKSTAT)
         cap_word = {{(DW-1){1'b0}}, brk_hit_q};
      else if (ir_q == `JEP_IR_EMUCTL)
         cap_word = {{(DW-`JEP_CTL_W){1'b0}}, ctl_q};
   end

   wire tap_rst = ~trst_n_s;
   wire tlm_in_load  = tck_rise & (st_q == ST_UDR) & (ir_q == `JEP_IR_TLM_IN);
   wire tlm_out_take = tck_rise & (st_q == ST_CDR) & (ir_q == `JEP_IR_TLM_OUT);
   wire core_rd_in   = io_rd_in & (io_addr_in == `JEP_TLM_IN_ADDR);
   wire core_wr_out  = io_wr_in & (io_addr_in == `JEP_TLM_OUT_ADDR);

   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q     <= ST_TLR;
         ir_sh_q  <= `JEP_IR_BYPASS;
         ir_q     <= `JEP_IR_BYPASS;
         bsr_sh_q <= {2*NPIN{1'b0}};
         bsr_q    <= {2*NPIN{1'b0}};
         dr_sh_q  <= {DW{1'b0}};
         xfer_q   <= {DW{1'b0}};
         ctl_q    <= {`JEP_CTL_W{1'b0}};
         byp_q    <= 1'b0;
         tdo_q    <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (clk_en_in) begin
         if (tap_rst) begin
            st_q <= ST_TLR;
            ir_q <= `JEP_IR_BYPASS;
            ctl_q <= {`JEP_CTL_W{1'b0}};
            tdo_oe_q <= 1'b0;
         end else begin
            if (core_op_done_in)
               xfer_q <= core_transfer_reg_in;
            if (tck_rise) begin
               st_q <= st_d;
               if (st_q == ST_TLR)
                  ir_q <= `JEP_IR_BYPASS;
               if (st_q == ST_CIR)
                  ir_sh_q <= `JEP_IR_CAPTURE;
               if (st_q == ST_SIR)
                  ir_sh_q <= {tdi_s, ir_sh_q[`JEP_IR_W-1:1]};
               if (st_q == ST_UIR)
                  ir_q <= ir_sh_q;
               if (st_q == ST_CDR) begin
                  bsr_sh_q <= bsr_cap;
                  dr_sh_q  <= cap_word;
                  byp_q    <= 1'b0;
               end
               if (st_q == ST_SDR) begin
                  bsr_sh_q <= {tdi_s, bsr_sh_q[2*NPIN-1:1]};
                  dr_sh_q  <= {tdi_s, dr_sh_q[DW-1:1]};
                  byp_q    <= tdi_s;
               end
               if (st_q == ST_UDR) begin
                  if (sel_bsr)
                     bsr_q <= bsr_sh_q;
                  if (ir_q == `JEP_IR_XFER)
                     xfer_q <= dr_sh_q;
                  if (ir_q == `JEP_IR_EMUCTL)
                     ctl_q <= dr_sh_q[`JEP_CTL_W-1:0];
               end
            end
            if (tck_fall) begin
               tdo_oe_q <= (st_q == ST_SDR) | (st_q == ST_SIR);
               if (st_q == ST_SIR)
                  tdo_q <= ir_sh_q[0];
               else if (sel_bsr)
                  tdo_q <= bsr_sh_q[0];
               else if (sel_word)
                  tdo_q <= dr_sh_q[0];
               else
                  tdo_q <= byp_q;
            end
         end
      end
   end
   assign tdo_out    = tdo_q;
   assign tdo_oe_out = tdo_oe_q;

   // ------------------------------------------------------------
   // Pin muxing through the scan cells
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_cell
         assign core_pin_in_out[gi] = in_test ? bsr_q[gi] : pin_in[gi];
         assign pin_out[gi] = out_test ? bsr_q[NPIN+gi] : core_pin_out_in[gi];
         assign pin_oe_out[gi] = out_test ? 1'b1 : core_pin_oe_in[gi];
      end
   endgenerate

   // ------------------------------------------------------------
   // Core side: telemetry, breakpoints, counters, registers
   // ------------------------------------------------------------
   reg           tlm_en_q;
   reg [AW-1:0]  brk_start_q;
   reg [AW-1:0]  brk_end_q;
   reg [2*DW-1:0] cyc_q;
   reg           done_q;
   wire brk_match = ctl_q[`JEP_CTL_BRKEN_BIT] & core_access_in &
                    (core_addr_in >= brk_start_q) & (core_addr_in <= brk_end_q);

   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tlm_en_q       <= 1'b0;
         tlm_in_q       <= {DW{1'b0}};
         tlm_out_q      <= {DW{1'b0}};
         tlm_in_full_q  <= 1'b0;
         tlm_out_full_q <= 1'b0;
         brk_start_q    <= {AW{1'b0}};
         brk_end_q      <= {AW{1'b0}};
         brk_hit_q      <= 1'b0;
         cyc_q          <= {2*DW{1'b0}};
         done_q         <= 1'b0;
      end else if (clk_en_in) begin
         cyc_q <= cyc_q + {{(2*DW-1){1'b0}}, 1'b1};
         if (io_wr_in & (io_addr_in == `JEP_TLM_STAT_ADDR))
            tlm_en_q <= io_wdata_in[`JEP_STAT_EN_BIT];
         if (io_wr_in & (io_addr_in == `JEP_BRK_START_ADDR))
            brk_start_q <= io_wdata_in[AW-1:0];
         if (io_wr_in & (io_addr_in == `JEP_BRK_END_ADDR))
            brk_end_q <= io_wdata_in[AW-1:0];
         if (tlm_in_load) begin
            tlm_in_q      <= dr_sh_q;
            tlm_in_full_q <= 1'b1;
         end else if (core_rd_in)
            tlm_in_full_q <= 1'b0;
         if (core_wr_out) begin
            tlm_out_q      <= io_wdata_in;
            tlm_out_full_q <= 1'b1;
         end else if (tlm_out_take)
            tlm_out_full_q <= 1'b0;
         // Set wins over the emulator's clear of the hit flag
         if (brk_match)
            brk_hit_q <= 1'b1;
         else if (tck_rise & (st_q == ST_UDR) & (ir_q == `JEP_IR_BRKSTAT))
            brk_hit_q <= 1'b0;
         if (core_op_done_in)
            done_q <= 1'b1;
         else if (tck_rise & (st_q == ST_UIR))
            done_q <= 1'b0;
      end
   end

   // Telemetry status word, fields placed by their named positions
   reg [DW-1:0] stat_word;
   always @* begin
      stat_word = {DW{1'b0}};
      stat_word[`JEP_STAT_EN_BIT]   = tlm_en_q;
      stat_word[`JEP_STAT_INF_BIT]  = tlm_in_full_q;
      stat_word[`JEP_STAT_OUTE_BIT] = ~tlm_out_full_q;
   end

   always @* begin
      io_rdata_out = {DW{1'b0}};
      if (io_addr_in == `JEP_REVID_ADDR)
         io_rdata_out = {{(DW-8){1'b0}}, REVISION};
      else if (io_addr_in == `JEP_TLM_STAT_ADDR)
         io_rdata_out = stat_word;
      else if (io_addr_in == `JEP_TLM_IN_ADDR)
         io_rdata_out = tlm_in_q;
      else if (io_addr_in == `JEP_BRK_START_ADDR)
         io_rdata_out = {{(DW-AW){1'b0}}, brk_start_q};
      else if (io_addr_in == `JEP_BRK_END_ADDR)
         io_rdata_out = {{(DW-AW){1'b0}}, brk_end_q};
      else if (io_addr_in == `JEP_EMU_STATE_ADDR)
         io_rdata_out = {{(DW-`JEP_CTL_W){1'b0}}, ctl_q};
      else if (io_addr_in == `JEP_CYC_LO_ADDR)
         io_rdata_out = cyc_q[DW-1:0];
      else if (io_addr_in == `JEP_CYC_HI_ADDR)
         io_rdata_out = cyc_q[2*DW-1:DW];
   end


   // ------------------------------------------------------------
   // Outputs to the core and the emulator
   // ------------------------------------------------------------
   // Interrupt levels feed the core's normal controller
   assign tlm_in_full_irq_out   = tlm_en_q & tlm_in_full_q;
   assign tlm_out_empty_irq_out = tlm_en_q & ~tlm_out_full_q;
   assign brk_irq_out           = brk_hit_q;
   assign core_halt_out         = ctl_q[`JEP_CTL_HALT_BIT];
   assign core_transfer_reg_out = xfer_q;
   assign emulation_done_pin_n_out = ~done_q;
endmodule
`default_nettype wire

// >>> verif/jep_port_assertions.sv
// Concurrent checks on the emulation port pins and register bus
`timescale 1ns/1ns
`default_nettype none
`include "jep_defs.vh"
module jep_port_assertions #(
   parameter       DW       = 32,
   parameter       AW       = 20,
   parameter [7:0] REVISION = 8'h5a
) (
   // Clock and reset
   input wire logic          clock_in,
   input wire logic          rst_n_in,
   input wire logic          clk_en_in,
   // Test access pins
   input wire logic          trst_n_in,
   input wire logic          tdo_oe_out,
   input wire logic          emulation_done_pin_n_out,
   // Register bus
   input wire logic          io_rd_in,
   input wire logic          io_wr_in,
   input wire logic [AW-1:0] io_addr_in,
   input wire logic [DW-1:0] io_rdata_out,
   // Core side
   input wire logic          core_access_in,
   input wire logic          core_op_done_in,
   input wire logic [DW-1:0] core_transfer_reg_in,
   input wire logic [DW-1:0] core_transfer_reg_out,
   input wire logic          core_halt_out,
   input wire logic          tlm_in_full_irq_out,
   input wire logic          tlm_out_empty_irq_out,
   input wire logic          brk_irq_out
);
   default clocking dcb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   chk_trst_clears: assert property (!trst_n_in [*6] |-> !core_halt_out && !tdo_oe_out)
      else $error("halt or shift state survives test reset");
   chk_done_flags: assert property (core_op_done_in && clk_en_in |=> !emulation_done_pin_n_out)
      else $error("done pin not asserted after core operation");
   chk_xfer_load: assert property (core_op_done_in && clk_en_in |=>
      core_transfer_reg_out == $past(core_transfer_reg_in))
      else $error("transfer register not loaded from core");
   chk_brk_cause: assert property ($rose(brk_irq_out) |-> $past(core_access_in))
      else $error("breakpoint raised without a core access");
   chk_in_clear: assert property (io_rd_in && clk_en_in && io_addr_in == `JEP_TLM_IN_ADDR
      |=> !tlm_in_full_irq_out)
      else $error("input buffer interrupt not cleared by read");
   chk_out_clear: assert property (io_wr_in && clk_en_in && io_addr_in == `JEP_TLM_OUT_ADDR
      |=> !tlm_out_empty_irq_out)
      else $error("output buffer interrupt not cleared by write");
   chk_rev_read: assert property (io_addr_in == `JEP_REVID_ADDR |-> io_rdata_out[7:0] == REVISION)
      else $error("revision register reads wrong value");
   chk_unmapped_zero: assert property (io_addr_in < `JEP_BRK_START_ADDR |-> io_rdata_out == '0)
      else $error("unmapped address reads non-zero");
   chk_freeze_hold: assert property (!clk_en_in |=> $stable(core_halt_out) && $stable(brk_irq_out)
      && $stable(core_transfer_reg_out))
      else $error("state moved while clock enable low");

   cov_brk: cover property ($rose(brk_irq_out));
   cov_tlm_in: cover property ($rose(tlm_in_full_irq_out));
   cov_done: cover property ($fell(emulation_done_pin_n_out));
endmodule
`default_nettype wire

// >>> verif/jep_probe.sv
// Emulator model that sequences the test access port
`timescale 1ns/1ns
`default_nettype none
module jep_probe (
   input  wire logic clock_in,
   input  wire logic tdo_in,
   output var  logic tck_out,
   output var  logic tms_out,
   output var  logic tdi_out,
   output var  logic trst_n_out
);
   initial begin
      tck_out    = 1'b0;
      tms_out    = 1'b1;
      tdi_out    = 1'b0;
      trst_n_out = 1'b0;
   end
   // One test clock period: drive while low, sample just before the fall
   task automatic step(input logic ms, input logic di, output logic bit_q);
      tms_out = ms;
      tdi_out = di;
      #32 tck_out = 1'b1;
      #32 bit_q = tdo_in;
      tck_out = 1'b0;
   endtask
   task automatic tap_reset();
      logic x;
      @(negedge clock_in);
      trst_n_out = 1'b0;
      #80 trst_n_out = 1'b1;
      #32 step(1'b0, ~tdi_out, x);
   endtask
   // Capture, shift n bits LSB first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic x;
      @(negedge clock_in);
      step(1'b1, ~tdi_out, x);
      if (ir) step(1'b1, ~tdi_out, x);
      step(1'b0, ~tdi_out, x);
      step(1'b0, ~tdi_out, x);
      dout = '0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], x);
         dout[i] = x;
      end
      step(1'b1, ~tdi_out, x);
      step(1'b0, ~tdi_out, x);
   endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the test and emulation port
`timescale 1ns/1ns
`default_nettype none
`include "jep_defs.vh"
module tb_top;
   localparam [7:0] REV = 8'h5a;
   logic        clock_in, rst_n_in, clk_en_in, tck, tms, tdi, trst_n, tdo, tdo_oe, done_n;
   logic [3:0]  pin_in, pin_out, pin_oe, core_pin_in, core_pin_out, core_oe;
   logic        io_rd, io_wr, core_acc, core_done, halt, irq_in, irq_out, brk;
   logic [19:0] io_addr, core_addr;
   logic [31:0] io_wdata, io_rdata, xfer_in, xfer_out, rd, so;
   int          err_total, comparisons;

   jep_port #(.NPIN(4), .REVISION(REV)) i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .trst_n_in(trst_n),
      .tdo_out(tdo), .tdo_oe_out(tdo_oe), .emulation_done_pin_n_out(done_n), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_out(pin_oe), .core_pin_in_out(core_pin_in),
      .core_pin_out_in(core_pin_out), .core_pin_oe_in(core_oe), .io_rd_in(io_rd), .io_wr_in(io_wr),
      .io_addr_in(io_addr), .io_wdata_in(io_wdata), .io_rdata_out(io_rdata),
      .core_access_in(core_acc), .core_addr_in(core_addr), .core_op_done_in(core_done),
      .core_transfer_reg_in(xfer_in), .core_transfer_reg_out(xfer_out), .core_halt_out(halt),
      .tlm_in_full_irq_out(irq_in), .tlm_out_empty_irq_out(irq_out), .brk_irq_out(brk));
   jep_probe i_probe (.clock_in(clock_in), .tdo_in(tdo), .tck_out(tck), .tms_out(tms),
      .tdi_out(tdi), .trst_n_out(trst_n));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic io_write(input logic [19:0] a, input logic [31:0] d);
      @(negedge clock_in);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clock_in);
      io_wr = 1'b0;
   endtask
   task automatic io_read(input logic [19:0] a);
      @(negedge clock_in);
      io_addr = a;
      io_rd = 1'b1;
      @(posedge clock_in);
      rd = io_rdata;
      @(negedge clock_in);
      io_rd = 1'b0;
   endtask
   task automatic core_access(input logic [19:0] a);
      @(negedge clock_in);
      core_addr = a;
      core_acc = 1'b1;
      @(negedge clock_in);
      core_acc = 1'b0;
   endtask
   task automatic ir(input logic [4:0] c);
      i_probe.scan(1'b1, 5, {27'h0, c}, so);
   endtask
   task automatic dr(input int n, input logic [31:0] d);
      i_probe.scan(1'b0, n, d, so);
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end
   initial begin
      #200_000;
      err_total++;
      give_verdict();
   end
   initial begin
      rst_n_in = 1'b0;
      clk_en_in = 1'b1;
      pin_in = 4'h9;
      core_pin_out = 4'h6;
      core_oe = 4'h5;
      {io_rd, io_wr, core_acc, core_done} = 4'h0;
      {io_addr, core_addr, io_wdata, xfer_in} = '0;
      err_total = 0;
      comparisons = 0;
      repeat (12) @(negedge clock_in);
      rst_n_in = 1'b1;
      i_probe.tap_reset();
      chk(done_n, 1'b1);
      chk(tdo_oe, 1'b0);
      io_read(`JEP_REVID_ADDR);
      chk(rd, {24'h0, REV});
      io_read(20'h00010);
      chk(rd, 32'h0);
      ir(`JEP_IR_BYPASS);
      chk({27'h0, so[4:0]}, 32'h1);
      dr(8, 32'ha5);
      chk(so, 32'h4a);
      $display("test reset done");
      ir(`JEP_IR_SAMPLE);
      dr(8, 32'h0);
      chk(so, 32'h69);
      ir(`JEP_IR_EXTEST);
      dr(8, 32'h3c);
      chk(pin_out, 4'h3);
      chk(pin_oe, 4'hf);
      ir(`JEP_IR_INTEST);
      dr(8, 32'ha5);
      chk(core_pin_in, 4'h5);
      chk(pin_out, 4'ha);
      ir(`JEP_IR_BYPASS);
      chk({pin_out, core_pin_in}, 8'h69);
      chk(pin_oe, 4'h5);
      $display("test boundary done");
      @(negedge clock_in);
      core_done = 1'b1;
      xfer_in = 32'hcafef00d;
      @(negedge clock_in);
      core_done = 1'b0;
      chk(done_n, 1'b0);
      ir(`JEP_IR_XFER);
      chk(done_n, 1'b1);
      dr(32, 32'h12345678);
      chk(so, 32'hcafef00d);
      chk(xfer_out, 32'h12345678);
      ir(`JEP_IR_REVID);
      dr(8, 32'h0);
      chk(so, {24'h0, REV});
      $display("test transfer done");
      io_write(`JEP_TLM_STAT_ADDR, 32'h1);
      io_read(`JEP_TLM_STAT_ADDR);
      chk(rd, 32'h5);
      chk(irq_out, 1'b1);
      ir(`JEP_IR_TLM_IN);
      dr(32, 32'h12345678);
      chk(irq_in, 1'b1);
      io_read(`JEP_TLM_STAT_ADDR);
      chk(rd, 32'h7);
      io_read(`JEP_TLM_IN_ADDR);
      chk(rd, 32'h12345678);
      chk(irq_in, 1'b0);
      io_write(`JEP_TLM_OUT_ADDR, 32'h9abcdef0);
      chk(irq_out, 1'b0);
      ir(`JEP_IR_TLM_OUT);
      dr(32, 32'h0);
      chk(so, 32'h9abcdef0);
      chk(irq_out, 1'b1);
      $display("test telemetry done");
      io_write(`JEP_BRK_START_ADDR, 32'h100);
      io_write(`JEP_BRK_END_ADDR, 32'h1ff);
      io_read(`JEP_BRK_START_ADDR);
      chk(rd, 32'h100);
      ir(`JEP_IR_EMUCTL);
      dr(32, 32'h3);
      chk(halt, 1'b1);
      io_write(`JEP_EMU_STATE_ADDR, 32'h0);
      io_read(`JEP_EMU_STATE_ADDR);
      chk(rd, 32'h3);
      io_write(`JEP_REVID_ADDR, 32'h0);
      io_read(`JEP_REVID_ADDR);
      chk(rd, {24'h0, REV});
      core_access(20'h0ff);
      chk(brk, 1'b0);
      core_access(20'h1ff);
      chk(brk, 1'b1);
      ir(`JEP_IR_BRKSTAT);
      dr(1, 32'h0);
      chk(so, 32'h1);
      $display("test breakpoint done");
      io_read(`JEP_CYC_LO_ADDR);
      so = rd;
      io_read(`JEP_CYC_LO_ADDR);
      chk(rd, so + 32'h2);
      @(negedge clock_in);
      clk_en_in = 1'b0;
      io_read(`JEP_CYC_LO_ADDR);
      so = rd;
      repeat (6) @(negedge clock_in);
      io_read(`JEP_CYC_LO_ADDR);
      chk(rd, so);
      clk_en_in = 1'b1;
      chk(halt, 1'b1);
      i_probe.tap_reset();
      chk(halt, 1'b0);
      dr(8, 32'ha5);
      chk(so, 32'h4a);
      $display("test test_reset done");
      give_verdict();
   end
endmodule

bind jep_port jep_port_assertions #(.DW(DW), .AW(AW), .REVISION(REVISION)) i_chk (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .trst_n_in(trst_n_in),
   .tdo_oe_out(tdo_oe_out), .emulation_done_pin_n_out(emulation_done_pin_n_out),
   .io_rd_in(io_rd_in), .io_wr_in(io_wr_in), .io_addr_in(io_addr_in),
   .io_rdata_out(io_rdata_out), .core_access_in(core_access_in),
   .core_op_done_in(core_op_done_in), .core_transfer_reg_in(core_transfer_reg_in),
   .core_transfer_reg_out(core_transfer_reg_out), .core_halt_out(core_halt_out),
   .tlm_in_full_irq_out(tlm_in_full_irq_out), .tlm_out_empty_irq_out(tlm_out_empty_irq_out),
   .brk_irq_out(brk_irq_out));
`default_nettype wire
